// File: reset_timeout_defs.vh
// constants for the reset time-out sequencer
`ifndef RESET_TIMEOUT_DEFS_VH
`define RESET_TIMEOUT_DEFS_VH

`define MCLK_HZ            100000000
`define LF_OSC_HZ          31000
`define LF_DIV             (`MCLK_HZ / `LF_OSC_HZ)
`define POWER_UP_DELAY_TIMER_TIME_MS       64
`define POWER_UP_DELAY_TIMER_TICKS         (`POWER_UP_DELAY_TIMER_TIME_MS * `LF_OSC_HZ / 1000)
`define WDT_MIN_TIME_MS    17
`define WDT_BASE_TICKS     (`WDT_MIN_TIME_MS * `LF_OSC_HZ / 1000)
`define OST_CYCLES         1024
`define BOR_FILTER_CYCLES  16

`define REG_POWER_FLAGS    4'h0
`define REG_STATUS         4'h1
`define REG_OPTION         4'h2

`define PWR_BOR_BIT        0
`define PWR_POR_BIT        1
`define OPT_RATE_LSB       0
`define OPT_ASSIGN_BIT     3

`define OPTION_RESET       8'h0f
`define POWER_FLAGS_RESET  2'h0

`define BOR_ALWAYS         2'h3
`define BOR_RUN_ONLY       2'h2

`define OSC_LP             3'h0
`define OSC_XT             3'h1
`define OSC_HS             3'h2
`define OSC_EXTERNAL_RC_MODE          3'h3
`define OSC_INTERNAL_OSC_MODE         3'h4
`define OSC_EC             3'h5
`define OSC_SECONDARY_OSC          3'h6

`endif

// File: lf_tick_div.v
// divider making the low-frequency oscillator tick enable
`timescale 1ns/10ps
`default_nettype none

module lf_tick_div #(
  parameter DIV = 3225
) (
  input  wire        mclk,
  input  wire        rst_n,
  output reg         tick
);

  reg [15:0] cnt_q;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: reset_timeout_sequencer.v
// reset time-out sequencer: power-up delay, oscillator start-up, watchdog, brown-out
//
// Overview of operation
// RQ1: after power-on or brown-out only, run a 64 ms delay holding reset.
// RQ2: whole chip stays in reset while the power-up delay runs.
// RQ3: configuration bit set disables the power-up delay, cleared enables it.
// RQ4: watchdog shares the 8-bit prescaler; assign and rate bits set its period.
// RQ5: watchdog period selectable from 17 ms up to about 2.2 s.
// RQ6: watchdog and power-up delay count ticks of the 31 kHz oscillator.
// RQ7: watchdog held in reset during oscillator start-up count, resumes after.
// RQ8: watchdog fuse set runs watchdog continuously; cleared keeps it cleared.
// RQ9: watchdog cleared by clear instruction and on non-crystal sleep exit.
// RQ10: crystal sleep exit keeps watchdog cleared until start-up count ends.
// RQ11: brown-out field 11 always on, 10 off in sleep, 0x off.
// RQ12: one configuration bit picks one of two brown-out trip levels.
// RQ13: supply below threshold longer than filter time gives brown-out reset.
// RQ14: brown-out during power-up delay restarts it for a full 64 ms.
// RQ15: program erase forces brown-out on at the lowest trip level.
// RQ16: power-up delay follows power-on pulse; start-up count follows delay.
// RQ17: external clock with delay disabled gives no time-out at all.
// RQ18: delays run under held master clear; release then starts at once.
// RQ19: bit 0 cleared by brown-out; software sets it.
// RQ20: bit 1 is 0 after power-on only; software writes 1.
// RQ21: time-out and power-down flags record watchdog, sleep and power-on causes.
// RQ22: master clear in normal run leaves all cause flags unchanged.
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "reset_timeout_defs.vh"

module reset_timeout_sequencer #(
  parameter POWER_UP_DELAY_TIMER_TICKS    = `POWER_UP_DELAY_TIMER_TICKS,
  parameter WDT_BASE      = `WDT_BASE_TICKS,
  parameter OST_CYCLES    = `OST_CYCLES,
  parameter BOR_FILTER    = `BOR_FILTER_CYCLES,
  parameter LF_DIV        = `LF_DIV
) (
  input  wire        mclk,
  input  wire        nrst,
  input  wire        master_clear_pin_n,
  input  wire [1:0]  brownout_trip,
  input  wire        power_up_delay_disable_n,
  input  wire        watchdog_enable_fuse,
  input  wire [1:0]  brownout_enable_sel,
  input  wire        brownout_level_sel,
  input  wire [2:0]  osc_mode,
  input  wire        flash_erase,
  input  wire        watchdog_clear_instr,
  input  wire        sleep_instr,
  input  wire        wake_event,
  input  wire [3:0]  addr,
  input  wire [7:0]  wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [7:0]  rd_data,
  output reg         chip_reset_q,
  output reg         watchdog_wake_q,
  output reg         timeout_flag_n,
  output reg         powerdown_flag_n
);

  localparam ST_POWER_UP_DELAY_TIMER   = 3'h0;
  localparam ST_OST    = 3'h1;
  localparam ST_RUN    = 3'h2;
  localparam ST_SLEEP  = 3'h3;
  localparam ST_BOR    = 3'h4;
  localparam ST_WDTRST = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function is_crystal;
    input [2:0] mode;
    begin
      is_crystal = (mode == `OSC_LP) || (mode == `OSC_XT) || (mode == `OSC_HS);
    end
  endfunction

  // watchdog limit in oscillator ticks
  function [16:0] wdt_limit;
    input       assign_wdt;
    input [2:0] rate;
    begin
      if (assign_wdt)
        wdt_limit = WDT_BASE[16:0] << rate; // [RQ4] [RQ5]
      else
        wdt_limit = WDT_BASE[16:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset and pin synchronisers

  reg        rst_s1_q;
  reg        rst_n;
  reg        master_clear_pin_n_s1_q;
  reg        master_clear_pin_n_s2_q;
  reg [1:0]  trip_s1_q;
  reg [1:0]  trip_s2_q;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      master_clear_pin_n_s1_q <= 1'b1;
      master_clear_pin_n_s2_q <= 1'b1;
      trip_s1_q <= 2'h0;
      trip_s2_q <= 2'h0;
    end else begin
      master_clear_pin_n_s1_q <= master_clear_pin_n;
      master_clear_pin_n_s2_q <= master_clear_pin_n_s1_q;
      trip_s1_q <= brownout_trip;
      trip_s2_q <= trip_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-frequency tick

  wire lf_tick;

  lf_tick_div #(
    .DIV (LF_DIV)
  ) u_lf_tick_div (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tick  (lf_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // brown-out detection

  reg  [2:0]  state_q;
  reg  [7:0]  bor_cnt_q;
  reg         bor_active_q;
  wire        bor_enabled;
  wire        bor_trip;

  assign bor_enabled = flash_erase ||                                  // [RQ15]
                       (brownout_enable_sel == `BOR_ALWAYS) ||         // [RQ11]
                       ((brownout_enable_sel == `BOR_RUN_ONLY) && (state_q != ST_SLEEP));
  assign bor_trip = flash_erase ? trip_s2_q[0] :                       // [RQ15]
                    trip_s2_q[brownout_level_sel];                     // [RQ12]

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bor_cnt_q    <= 8'h00;
      bor_active_q <= 1'b0;
    end else if (!bor_enabled || !bor_trip) begin
      bor_cnt_q    <= 8'h00;
      bor_active_q <= 1'b0;
    end else if (bor_cnt_q == BOR_FILTER[7:0]) begin
      bor_active_q <= 1'b1; // [RQ13]
    end else begin
      bor_cnt_q    <= bor_cnt_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // option register and counters

  reg  [7:0]  option_q;
  reg  [10:0] power_up_delay_timer_cnt_q;
  reg  [10:0] ost_cnt_q;
  reg  [16:0] wdt_cnt_q;
  wire        power_up_delay_timer_done;
  wire        ost_done;
  wire        wdt_expire;
  wire        wdt_hold;
  wire        crystal;
  wire        delay_on;

  assign crystal    = is_crystal(osc_mode);
  assign delay_on   = !power_up_delay_disable_n;                         // [RQ3]
  assign power_up_delay_timer_done  = lf_tick && (power_up_delay_timer_cnt_q == POWER_UP_DELAY_TIMER_TICKS[10:0] - 11'h001);
  assign ost_done   = (ost_cnt_q == OST_CYCLES[10:0] - 11'h001);
  assign wdt_expire = watchdog_enable_fuse && lf_tick && !wdt_hold &&
                      (wdt_cnt_q == wdt_limit(option_q[`OPT_ASSIGN_BIT],
                                              option_q[`OPT_RATE_LSB +: 3]) - 17'h00001);
  assign wdt_hold   = (state_q == ST_OST) || !watchdog_enable_fuse ||   // [RQ7] [RQ8] [RQ10]
                      watchdog_clear_instr ||                           // [RQ9]
                      !master_clear_pin_n_s2_q ||                                     // [RQ21]
                      (state_q == ST_SLEEP && wake_event) ||            // [RQ9]
                      (state_q != ST_RUN && state_q != ST_SLEEP);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      power_up_delay_timer_cnt_q <= 11'h000;
      ost_cnt_q  <= 11'h000;
      wdt_cnt_q  <= 17'h00000;
    end else begin
      if (state_q != ST_POWER_UP_DELAY_TIMER)
        power_up_delay_timer_cnt_q <= 11'h000;                                          // [RQ14]
      else if (lf_tick)
        power_up_delay_timer_cnt_q <= power_up_delay_timer_cnt_q + 11'h001;                             // [RQ6]
      if (state_q != ST_OST)
        ost_cnt_q <= 11'h000;
      else
        ost_cnt_q <= ost_cnt_q + 11'h001;
      if (wdt_hold || wdt_expire)
        wdt_cnt_q <= 17'h00000;
      else if (lf_tick)
        wdt_cnt_q <= wdt_cnt_q + 17'h00001;                             // [RQ6] [RQ8]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  reg [2:0] state_d;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_POWER_UP_DELAY_TIMER: begin
        if (power_up_delay_timer_done)
          state_d = crystal ? ST_OST : ST_RUN;                          // [RQ1] [RQ16]
      end
      ST_OST: begin
        if (ost_done)
          state_d = ST_RUN;                                             // [RQ7] [RQ16]
      end
      ST_RUN: begin
        if (wdt_expire)
          state_d = ST_WDTRST;
        else if (sleep_instr && master_clear_pin_n_s2_q)
          state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!master_clear_pin_n_s2_q || wake_event)
          state_d = crystal ? ST_OST : ST_RUN;                          // [RQ9] [RQ10]
        else if (wdt_expire)
          state_d = crystal ? ST_OST : ST_RUN;
      end
      ST_BOR: begin
        if (!bor_active_q) begin
          if (delay_on)
            state_d = ST_POWER_UP_DELAY_TIMER;                                          // [RQ14]
          else
            state_d = crystal ? ST_OST : ST_RUN;                        // [RQ17]
        end
      end
      ST_WDTRST: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    if (bor_active_q)
      state_d = ST_BOR;                                                 // [RQ13] [RQ14]
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      state_q <= ST_BOR;
    else
      state_q <= state_d;
  end

  // reset out: sequence states hold reset; master clear low also forces it
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chip_reset_q    <= 1'b1;
      watchdog_wake_q <= 1'b0;
    end else begin
      chip_reset_q    <= !master_clear_pin_n_s2_q ||                                  // [RQ18]
                         (state_d != ST_RUN && state_d != ST_SLEEP);    // [RQ2]
      watchdog_wake_q <= (state_q == ST_SLEEP) && wdt_expire && master_clear_pin_n_s2_q &&
                         !wake_event && !bor_active_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cause flags and registers

  reg [1:0] pwr_flags_q;
  wire      bor_event;

  assign bor_event = bor_active_q && (state_q != ST_BOR);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_flags_q      <= `POWER_FLAGS_RESET;                           // [RQ20] [RQ19]
      timeout_flag_n   <= 1'b1;                                         // [RQ21]
      powerdown_flag_n <= 1'b1;                                         // [RQ21]
      option_q         <= `OPTION_RESET;
    end else begin
      if (wr_en && addr == `REG_POWER_FLAGS)
        pwr_flags_q <= wr_data[1:0];                                    // [RQ19] [RQ20]
      if (wr_en && addr == `REG_OPTION)
        option_q <= wr_data;                                            // [RQ4]
      if (bor_event) begin
        pwr_flags_q[`PWR_BOR_BIT] <= 1'b0;                              // [RQ19]
        timeout_flag_n            <= 1'b1;
        powerdown_flag_n          <= 1'b1;
      end else if (state_q == ST_RUN && wdt_expire) begin
        timeout_flag_n   <= 1'b0;                                       // [RQ21]
      end else if (state_q == ST_SLEEP && !master_clear_pin_n_s2_q) begin
        timeout_flag_n   <= 1'b1;                                       // [RQ21]
        powerdown_flag_n <= 1'b0;
      end else if (state_q == ST_SLEEP && !wake_event && wdt_expire) begin
        timeout_flag_n   <= 1'b0;                                       // [RQ21]
        powerdown_flag_n <= 1'b0;
      end else if (state_q == ST_RUN && master_clear_pin_n_s2_q && sleep_instr) begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b0;
      end else if (state_q == ST_RUN && master_clear_pin_n_s2_q && watchdog_clear_instr) begin
        timeout_flag_n   <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
      // master clear in run touches no flag [RQ22]
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        `REG_POWER_FLAGS: rd_data <= {6'h00, pwr_flags_q};
        `REG_STATUS:      rd_data <= {3'h0, state_q, powerdown_flag_n, timeout_flag_n};
        `REG_OPTION:      rd_data <= option_q;
        default:          rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// File: reset_timeout_chk.sv
// assertion checker for the reset time-out sequencer
`timescale 1ns/10ps
`default_nettype none
module reset_timeout_chk (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       master_clear_pin_n,
  input wire logic [1:0] brownout_trip,
  input wire logic       power_up_delay_disable_n,
  input wire logic       watchdog_enable_fuse,
  input wire logic [1:0] brownout_enable_sel,
  input wire logic       brownout_level_sel,
  input wire logic [2:0] osc_mode,
  input wire logic       flash_erase,
  input wire logic       sleep_instr,
  input wire logic       chip_reset_q,
  input wire logic       watchdog_wake_q,
  input wire logic       timeout_flag_n,
  input wire logic       powerdown_flag_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  hold_por_a: assert property (
    $rose(nrst) && !power_up_delay_disable_n |-> chip_reset_q [*8])
    else $error("reset fell during power-up delay");
  no_delay_a: assert property (
    $rose(nrst) && power_up_delay_disable_n && osc_mode == 3'h5 && master_clear_pin_n
    && brownout_enable_sel == 2'h0 && !flash_erase |-> ##[1:10] !chip_reset_q)
    else $error("time-out applied with no delay configured");
  master_clear_pin_n_hold_a: assert property (
    !master_clear_pin_n [*4] |-> chip_reset_q)
    else $error("core runs with master clear low");
  wake_pulse_a: assert property (
    watchdog_wake_q |=> !watchdog_wake_q)
    else $error("wake pulse longer than one cycle");
  wake_flags_a: assert property (
    watchdog_wake_q |-> ##[0:2] (!timeout_flag_n && !powerdown_flag_n))
    else $error("watchdog wake without both flags cleared");
  fuse_off_a: assert property (
    !watchdog_enable_fuse |-> !watchdog_wake_q)
    else $error("watchdog fired with fuse cleared");
  sleep_flags_a: assert property (
    sleep_instr && !chip_reset_q && master_clear_pin_n
    |-> ##[1:3] (timeout_flag_n && !powerdown_flag_n))
    else $error("sleep entry flags wrong");
  bor_trip_a: assert property (
    (brownout_enable_sel == 2'h3 && brownout_trip[brownout_level_sel]) [*8]
    |-> chip_reset_q)
    else $error("no brown-out reset");
  erase_bor_a: assert property (
    (flash_erase && brownout_trip[0]) [*8] |-> chip_reset_q)
    else $error("no brown-out reset during erase");
endmodule
bind reset_timeout_sequencer reset_timeout_chk chk_u (
  .mclk(mclk), .nrst(nrst), .master_clear_pin_n(master_clear_pin_n),
  .brownout_trip(brownout_trip), .power_up_delay_disable_n(power_up_delay_disable_n),
  .watchdog_enable_fuse(watchdog_enable_fuse), .brownout_enable_sel(brownout_enable_sel),
  .brownout_level_sel(brownout_level_sel), .osc_mode(osc_mode), .flash_erase(flash_erase),
  .sleep_instr(sleep_instr), .chip_reset_q(chip_reset_q), .watchdog_wake_q(watchdog_wake_q),
  .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n));
`default_nettype wire

// File: core_pin_model.sv
// core and master clear pin stand-in
`timescale 1ns/10ps
`default_nettype none
module core_pin_model (
  input  wire logic mclk,
  input  wire logic crst,
  input  wire logic mc_lo,
  input  wire logic q_clr,
  input  wire logic q_slp,
  output wire logic master_clear_pin_n_n,
  output var logic  clr_i = 1'b0,
  output var logic  slp_i = 1'b0
);
  ////////////////////////////////////////
  assign master_clear_pin_n_n = !mc_lo;
  // instructions issue only while the core runs
  always @(posedge mclk) begin
    clr_i <= q_clr && !crst;
    slp_i <= q_slp && !crst;
  end
endmodule
`default_nettype wire

// File: reset_timeout_sequencer_tb_top.sv
// self-checking bench for the reset time-out sequencer
`timescale 1ns/10ps
`default_nettype none
`include "reset_timeout_defs.vh"
module reset_timeout_sequencer_tb_top;
  localparam int LD = 4;
  localparam int PT = 8;
  localparam int WB = 4;
  localparam int OC = 16;
  logic       mclk = 1'b0;
  logic       nrst = 1'b0;
  logic [1:0] trip = 2'h0;
  logic       dis_n = 1'b0;
  logic       fuse = 1'b0;
  logic [1:0] bsel = 2'h0;
  logic       lsel = 1'b0;
  logic [2:0] osc = `OSC_EC;
  logic       erase = 1'b0;
  logic       mc_lo = 1'b0;
  logic       q_clr = 1'b0;
  logic       q_slp = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdat = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic       wake = 1'b0;
  wire  [7:0] rdat;
  wire        crst;
  wire        wwake;
  wire        to_n;
  wire        pd_n;
  wire        master_clear_pin_n_n;
  wire        clr_i;
  wire        slp_i;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;
  int         hi = 0;
  int         n;
  int         h0;
  logic [7:0] v;
  ////////////////////////////////////////
  reset_timeout_sequencer #(.POWER_UP_DELAY_TIMER_TICKS(PT), .WDT_BASE(WB), .OST_CYCLES(OC),
    .BOR_FILTER(2), .LF_DIV(LD)) dut_u (
    .mclk(mclk), .nrst(nrst), .master_clear_pin_n(master_clear_pin_n_n), .brownout_trip(trip),
    .power_up_delay_disable_n(dis_n), .watchdog_enable_fuse(fuse),
    .brownout_enable_sel(bsel), .brownout_level_sel(lsel), .osc_mode(osc),
    .flash_erase(erase), .watchdog_clear_instr(clr_i), .sleep_instr(slp_i),
    .wake_event(wake), .addr(addr), .wr_data(wdat), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rdat), .chip_reset_q(crst), .watchdog_wake_q(wwake),
    .timeout_flag_n(to_n), .powerdown_flag_n(pd_n));
  core_pin_model core_u (.mclk(mclk), .crst(crst), .mc_lo(mc_lo), .q_clr(q_clr),
    .q_slp(q_slp), .master_clear_pin_n_n(master_clear_pin_n_n), .clr_i(clr_i), .slp_i(slp_i));
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (crst === 1'b1) hi++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rng(input int k, input int a, input int b);
    chk(16'(k >= a && k <= b), 16'h1);
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic wl(input logic lv, output int k);
    k = 0;
    while (crst !== lv && k < 400) begin
      cy(1);
      k++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdat <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 d = rdat;
  endtask
  task automatic por(input logic d, input logic [2:0] o, input logic f);
    @(posedge mclk);
    dis_n <= d;
    osc <= o;
    fuse <= f;
    nrst <= 1'b0;
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    wl(1'b0, n);
  endtask
  task automatic cfg(input logic [1:0] bs, input logic ls, input logic er,
                     input logic [1:0] t, input int k);
    @(posedge mclk);
    bsel <= bs;
    lsel <= ls;
    erase <= er;
    trip <= t;
    cy(k);
  endtask
  task automatic pulse_clr;
    @(posedge mclk);
    q_clr <= 1'b1;
    @(posedge mclk);
    q_clr <= 1'b0;
  endtask
  task automatic pulse_slp;
    @(posedge mclk);
    q_slp <= 1'b1;
    @(posedge mclk);
    q_slp <= 1'b0;
  endtask
  task automatic master_clear_pin_n_blip;
    @(posedge mclk);
    mc_lo <= 1'b1;
    cy(6);
    @(posedge mclk);
    mc_lo <= 1'b0;
    wl(1'b0, n);
  endtask
  ////////////////////////////////////////
  task automatic t_power;
    por(1'b0, `OSC_EC, 1'b0);
    rng(n, (PT - 1) * LD, PT * LD + 12);
    rd(`REG_POWER_FLAGS, v);
    chk(v[1], 1'b0);
    chk({to_n, pd_n}, 2'b11);
    rd(`REG_OPTION, v);
    chk(v, `OPTION_RESET);
    por(1'b0, `OSC_XT, 1'b0);
    rng(n, (PT - 1) * LD + OC, PT * LD + OC + 12);
    por(1'b1, `OSC_EC, 1'b0);
    rng(n, 0, 10);
    por(1'b1, `OSC_XT, 1'b0);
    rng(n, OC, OC + 12);
    $display("power-up test done");
  endtask
  task automatic t_master_clear_pin_n;
    @(posedge mclk);
    mc_lo <= 1'b1;
    por(1'b0, `OSC_EC, 1'b0);
    chk(crst, 1'b1);
    @(posedge mclk);
    mc_lo <= 1'b0;
    wl(1'b0, n);
    rng(n, 0, 6);
    wr(`REG_POWER_FLAGS, 8'h03);
    master_clear_pin_n_blip();
    rd(`REG_POWER_FLAGS, v);
    chk(v[1:0], 2'b11);
    chk({to_n, pd_n}, 2'b11);
    $display("master clear test done");
  endtask
  task automatic t_wdt;
    por(1'b1, `OSC_EC, 1'b1);
    wr(`REG_OPTION, 8'h00);
    pulse_clr();
    wl(1'b1, n);
    rng(n, (WB - 1) * LD, WB * LD + 10);
    wl(1'b0, n);
    chk(to_n, 1'b0);
    wr(`REG_OPTION, 8'h09);
    pulse_clr();
    wl(1'b1, n);
    rng(n, (2 * WB - 1) * LD, 2 * WB * LD + 10);
    wl(1'b0, n);
    wr(`REG_OPTION, 8'h00);
    h0 = hi;
    repeat (8) begin
      pulse_clr();
      cy(6);
    end
    chk(16'(hi - h0), 16'h0);
    por(1'b1, `OSC_EC, 1'b0);
    wr(`REG_OPTION, 8'h00);
    h0 = hi;
    cy(200);
    chk(16'(hi - h0), 16'h0);
    $display("watchdog test done");
  endtask
  task automatic t_sleep;
    por(1'b1, `OSC_EC, 1'b1);
    wr(`REG_OPTION, 8'h00);
    pulse_slp();
    cy(3);
    chk({to_n, pd_n}, 2'b10);
    n = 0;
    while (wwake !== 1'b1 && n < 100) begin
      cy(1);
      n++;
    end
    rng(n, 1, WB * LD + 10);
    cy(2);
    chk({to_n, pd_n}, 2'b00);
    pulse_slp();
    master_clear_pin_n_blip();
    chk({to_n, pd_n}, 2'b10);
    $display("sleep test done");
  endtask
  task automatic t_wake;
    por(1'b1, `OSC_XT, 1'b1);
    wr(`REG_OPTION, 8'h00);
    pulse_slp();
    @(posedge mclk);
    wake <= 1'b1;
    @(posedge mclk);
    wake <= 1'b0;
    cy(1);
    chk(crst, 1'b1);
    wl(1'b0, n);
    rng(n, OC - 4, OC + 4);
    chk({to_n, pd_n}, 2'b10);
    wl(1'b1, n);
    rng(n, (WB - 1) * LD, WB * LD + 4);
    wl(1'b0, n);
    $display("wake test done");
  endtask
  task automatic t_bor;
    cfg(2'h3, 1'b0, 1'b0, 2'h0, 0);
    por(1'b0, `OSC_EC, 1'b0);
    wr(`REG_POWER_FLAGS, 8'h03);
    cfg(2'h3, 1'b0, 1'b0, 2'h1, 8);
    chk(crst, 1'b1);
    cfg(2'h3, 1'b0, 1'b0, 2'h0, PT * LD / 2);
    cfg(2'h3, 1'b0, 1'b0, 2'h1, 8);
    cfg(2'h3, 1'b0, 1'b0, 2'h0, 0);
    wl(1'b0, n);
    rng(n, (PT - 1) * LD, PT * LD + 12);
    rd(`REG_POWER_FLAGS, v);
    chk(v[1:0], 2'b10);
    h0 = hi;
    cfg(2'h3, 1'b1, 1'b0, 2'h1, 20);
    chk(16'(hi - h0), 16'h0);
    cfg(2'h3, 1'b1, 1'b0, 2'h2, 8);
    chk(crst, 1'b1);
    cfg(2'h0, 1'b1, 1'b0, 2'h3, 0);
    wl(1'b0, n);
    h0 = hi;
    cy(20);
    chk(16'(hi - h0), 16'h0);
    cfg(2'h0, 1'b1, 1'b1, 2'h1, 8);
    chk(crst, 1'b1);
    cfg(2'h0, 1'b0, 1'b0, 2'h0, 0);
    $display("brown-out test done");
  endtask
  initial begin
    t_power();
    t_master_clear_pin_n();
    t_wdt();
    t_sleep();
    t_wake();
    t_bor();
    give_verdict();
  end
endmodule
`default_nettype wire
